/* verilog/fps_pkg.sv */
package fps_pkg;

   // clock
   localparam int FPS_CLK_PERIOD_NS = 40;

   // special function register addresses
   localparam logic [7:0] FPS_ADDR_CMD = 8'hb9;
   localparam logic [7:0] FPS_ADDR_ADDR_HIGH = 8'hc7;
   localparam logic [7:0] FPS_ADDR_ADDR_LOW = 8'hc6;
   localparam logic [7:0] FPS_ADDR_DATA = 8'hbc;
   localparam logic [7:0] FPS_ADDR_KEY = 8'hc1;
   localparam logic [7:0] FPS_ADDR_PROT_B0 = 8'hc2;
   localparam logic [7:0] FPS_ADDR_PROT_B1 = 8'hc3;
   localparam logic [7:0] FPS_ADDR_PROT_READ = 8'hc4;
   localparam logic [7:0] FPS_ADDR_PROT_KEY = 8'hc5;
   localparam logic [7:0] FPS_ADDR_STATUS = 8'hbe;

   // status register bit positions
   localparam int FPS_STAT_BUSY = 0;
   localparam int FPS_STAT_REFUSED = 1;
   localparam int FPS_STAT_DOWNLOAD = 2;
   localparam int FPS_STAT_SCHEME = 3;

   // reset values
   localparam logic [7:0] FPS_RST_BYTE = 8'h00;
   localparam logic [7:0] FPS_RST_PROT_BYTE = 8'hff;
   localparam logic [47:0] FPS_RST_PROT_ALL = 48'hffff_ffff_ffff;

   // access key and emulator command codes
   localparam logic [7:0] FPS_ACCESS_KEY = 8'h3b;
   localparam logic [7:0] FPS_EMU_LOAD = 8'h49;
   localparam logic [7:0] FPS_EMU_STORE = 8'h46;

   // flash command codes
   localparam logic [7:0] FPS_CMD_WRITE = 8'h01;
   localparam logic [7:0] FPS_CMD_ERASE_PAGE = 8'h02;
   localparam logic [7:0] FPS_CMD_ERASE_ALL = 8'h03;
   localparam logic [7:0] FPS_CMD_READ = 8'h04;
   localparam logic [7:0] FPS_CMD_ERASE_WRITE = 8'h05;
   localparam logic [7:0] FPS_CMD_VERIFY = 8'h06;
   localparam logic [7:0] FPS_CMD_PROTECT = 8'h08;

   // protected array geometry
   localparam int FPS_PAGE_LSB = 9;
   localparam int FPS_PAGES = 32;
   localparam int FPS_PROT_BYTES = 6;

   // operation times and derived cycle counts
   localparam int FPS_T_WRITE_NS = 30000;
   localparam int FPS_T_READ_NS = 100;
   localparam int FPS_T_ERASE_PAGE_US = 20000;
   localparam int FPS_T_ERASE_ALL_US = 200000;
   localparam int FPS_T_ERASE_WRITE_US = 21000;
   localparam int FPS_CYC_WRITE = (FPS_T_WRITE_NS + FPS_CLK_PERIOD_NS - 1) / FPS_CLK_PERIOD_NS;
   localparam int FPS_CYC_READ = (FPS_T_READ_NS + FPS_CLK_PERIOD_NS - 1) / FPS_CLK_PERIOD_NS;
   localparam int FPS_CYC_ERASE_PAGE = FPS_T_ERASE_PAGE_US * 1000 / FPS_CLK_PERIOD_NS;
   localparam int FPS_CYC_ERASE_ALL = FPS_T_ERASE_ALL_US * 1000 / FPS_CLK_PERIOD_NS;
   localparam int FPS_CYC_ERASE_WRITE = FPS_T_ERASE_WRITE_US * 1000 / FPS_CLK_PERIOD_NS;
   localparam int FPS_CNT_W = 23;

   // operation sequencer states
   typedef enum logic [1:0]
   {
      FPS_IDLE = 2'b00,
      FPS_RUN = 2'b01,
      FPS_DONE = 2'b11
   } fps_phase_type;

   // emulator command from the download kernel
   typedef struct packed
   {
      logic valid;
      logic [7:0] code;
      logic [7:0] data;
   } fps_emu_type;

   // register access from the core
   typedef struct packed
   {
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } fps_sfr_type;

   // request to the flash array
   typedef struct packed
   {
      logic go;
      logic [7:0] cmd;
      logic [13:0] addr;
      logic [7:0] wdata;
      logic [47:0] prot;
   } fps_flash_type;

   // whole module state
   typedef struct packed
   {
      logic [2:0] strap_sync;
      logic strap_pending;
      logic download;
      logic [31:0] wp;
      logic [7:0] rp;
      logic [7:0] pkey;
      logic [7:0] cmd;
      logic [7:0] addr_high;
      logic [7:0] addr_low;
      logic [7:0] data;
      logic [7:0] key;
      logic [7:0] prot_b0;
      logic [7:0] prot_b1;
      logic [7:0] prot_read;
      logic [7:0] prot_key;
      logic [7:0] r0;
      logic [7:0] rdata;
      logic refused;
      fps_phase_type phase;
      logic [22:0] cnt;
      fps_flash_type flash;
   } fps_state_type;

endpackage

/* verilog/fps_top.sv */
// Contract
// RULE1 - emulator register-write commands act only in download mode, else ignored
// RULE2 - emulator code 0x49 loads its data byte into working register zero
// RULE3 - emulator code 0x46 copies working register zero to the addressed register
// RULE4 - host sends load then store per register write; address high is 0xC7
// RULE5 - erased protection bits leave every page readable, writable and erasable
// RULE6 - protection works only when the last page is write/erase protected
// RULE7 - newly programmed protection takes effect only after the next reset
// RULE8 - after activation, protection clears only through a whole array erase
// RULE9 - read-and-write protected last page hides protection bits, still programmable
// RULE10 - protection bits may always go from 1 to 0, never back; code refuses 08H once a key is set unless the protection key matches
// RULE11 - op times: write 30us, page erase 20ms, all 200ms, 21ms, read 100ns
// RULE12 - writing the command register stalls the core until the op finishes
// RULE13 - no interrupts serviced during an op; timers keep counting
// RULE14 - download enable low at reset release enters serial download mode
// RULE15 - download mode runs the download kernel, flash programmable over the UART
// RULE16 - download mode refuses reads of read-protected pages
// RULE17 - download mode refuses write and erase of write-protected pages
// RULE18 - download kernel's own operations may not program the protection bits
// RULE19 - every op needs the access key written first, else it is not run
// RULE20 - command 08H programs the staged protection bytes
// RULE21 - protection settings live at 0x3FFA to 0x3FFF, a 0 bit protects
// RULE22 - one read bit guards four pages; write/erase protection is per page
// RULE23 - busy holds for the whole op and drives stall and interrupt block
`timescale 1ns/1ps
module fps_top
   import fps_pkg::*;
#(
   parameter int P_CYC_ERASE_PAGE = FPS_CYC_ERASE_PAGE,
   parameter int P_CYC_ERASE_ALL = FPS_CYC_ERASE_ALL,
   parameter int P_CYC_ERASE_WRITE = FPS_CYC_ERASE_WRITE
)
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_download_enable_n,
   input wire fps_sfr_type i_sfr,
   input wire fps_emu_type i_emu,
   input wire logic [47:0] i_nv_prot,
   input wire logic [7:0] i_flash_rdata,
   output fps_flash_type o_flash,
   output logic [7:0] o_sfr_rdata,
   output logic [7:0] o_working_register_zero,
   output logic o_download_mode,
   output logic o_core_stall,
   output logic o_irq_block,
   output logic o_op_refused
);

   // elaboration check on the long counts
   localparam int MAX_CNT = (1 << FPS_CNT_W) - 1;
   if (P_CYC_ERASE_PAGE < 1 || P_CYC_ERASE_PAGE > MAX_CNT ||
       P_CYC_ERASE_ALL < 1 || P_CYC_ERASE_ALL > MAX_CNT ||
       P_CYC_ERASE_WRITE < 1 || P_CYC_ERASE_WRITE > MAX_CNT)
   begin : g_bad_count
      $error("fps_top: operation cycle count out of range");
   end

   localparam logic [22:0] CNT_WRITE = 23'(FPS_CYC_WRITE);
   localparam logic [22:0] CNT_READ = 23'(FPS_CYC_READ);
   localparam logic [22:0] CNT_PROTECT = 23'(FPS_CYC_WRITE * FPS_PROT_BYTES);
   localparam logic [22:0] CNT_ERASE_PAGE = 23'(P_CYC_ERASE_PAGE);
   localparam logic [22:0] CNT_ERASE_ALL = 23'(P_CYC_ERASE_ALL);
   localparam logic [22:0] CNT_ERASE_WRITE = 23'(P_CYC_ERASE_WRITE);

   fps_state_type state;
   fps_state_type next_state;

   // per-page permissions from the applied protection
   logic scheme_on;
   logic [FPS_PAGES-1:0] page_read_ok;
   logic [FPS_PAGES-1:0] page_write_ok;

   // scheme is off unless the last page is write protected
   assign scheme_on = ~state.wp[FPS_PAGES-1]; // [RULE6] [RULE5]

   genvar pg;
   generate
      for (pg = 0; pg < FPS_PAGES; pg++)
      begin : g_page
         // a read bit covers four pages, write bits one page each
         assign page_read_ok[pg] = ~scheme_on | state.rp[pg/4]; // [RULE22] [RULE16]
         assign page_write_ok[pg] = ~scheme_on | state.wp[pg]; // [RULE22] [RULE17]
      end
   endgenerate

   // effective register write: emulator store wins over the core
   logic emu_store;
   logic wr_en;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic wr_from_emu;
   logic [4:0] cur_page;
   logic key_ok;
   logic allowed;
   logic [22:0] op_cycles;

   assign emu_store = i_emu.valid & state.download & (i_emu.code == FPS_EMU_STORE); // [RULE1]
   assign wr_from_emu = emu_store;
   assign wr_en = emu_store | i_sfr.wr;
   assign wr_addr = emu_store ? i_emu.data : i_sfr.addr; // [RULE3] [RULE4]
   assign wr_data = emu_store ? state.r0 : i_sfr.wdata; // [RULE3]
   assign cur_page = state.addr_high[5:1];
   assign key_ok = state.key == FPS_ACCESS_KEY; // [RULE19]

   // permission and duration of a command
   always_comb
   begin
      allowed = 1'b0;
      op_cycles = CNT_READ;
      case (wr_data)
         FPS_CMD_WRITE:
         begin
            allowed = page_write_ok[cur_page]; // [RULE17] [RULE9]
            op_cycles = CNT_WRITE; // [RULE11]
         end
         FPS_CMD_ERASE_PAGE:
         begin
            allowed = page_write_ok[cur_page]; // [RULE17] [RULE9]
            op_cycles = CNT_ERASE_PAGE; // [RULE11]
         end
         FPS_CMD_ERASE_ALL:
         begin
            allowed = 1'b1; // [RULE8]
            op_cycles = CNT_ERASE_ALL; // [RULE11]
         end
         FPS_CMD_READ, FPS_CMD_VERIFY:
         begin
            allowed = ~state.download | page_read_ok[cur_page]; // [RULE16] [RULE9]
            op_cycles = CNT_READ; // [RULE11]
         end
         FPS_CMD_ERASE_WRITE:
         begin
            allowed = page_write_ok[cur_page]; // [RULE17]
            op_cycles = CNT_ERASE_WRITE; // [RULE11]
         end
         FPS_CMD_PROTECT:
         begin
            // kernel code may not program protection; emulator stores may
            allowed = (~state.download | wr_from_emu) & // [RULE18]
               (state.pkey == FPS_RST_PROT_BYTE || state.prot_key == state.pkey); // [RULE10]
            op_cycles = CNT_PROTECT;
         end
         default:
         begin
            allowed = 1'b0;
            op_cycles = CNT_READ;
         end
      endcase
   end

   // next state
   always_comb
   begin
      next_state = state;
      next_state.flash.go = 1'b0;
      // three-stage strap synchroniser runs through reset
      next_state.strap_sync = {state.strap_sync[1:0], i_download_enable_n};

      // strap and protection are caught once after reset release
      if (state.strap_pending && state.strap_sync[1] == state.strap_sync[2])
      begin
         next_state.strap_pending = 1'b0;
         next_state.download = ~state.strap_sync[2]; // [RULE14] [RULE15]
         // programmed bits apply only from here on
         next_state.wp = i_nv_prot[47:16]; // [RULE7] [RULE21]
         next_state.rp = i_nv_prot[15:8]; // [RULE21]
         next_state.pkey = i_nv_prot[7:0]; // [RULE21]
      end

      // emulator load into working register zero
      if (i_emu.valid && state.download && i_emu.code == FPS_EMU_LOAD)
      begin
         next_state.r0 = i_emu.data; // [RULE1] [RULE2]
      end

      // register reads answer one cycle later
      case (i_sfr.addr)
         FPS_ADDR_CMD:
         begin
            next_state.rdata = state.cmd;
         end
         FPS_ADDR_ADDR_HIGH:
         begin
            next_state.rdata = state.addr_high;
         end
         FPS_ADDR_ADDR_LOW:
         begin
            next_state.rdata = state.addr_low;
         end
         FPS_ADDR_DATA:
         begin
            next_state.rdata = state.data;
         end
         FPS_ADDR_PROT_B0:
         begin
            next_state.rdata = state.prot_b0;
         end
         FPS_ADDR_PROT_B1:
         begin
            next_state.rdata = state.prot_b1;
         end
         FPS_ADDR_PROT_READ:
         begin
            next_state.rdata = state.prot_read;
         end
         FPS_ADDR_STATUS:
         begin
            next_state.rdata = FPS_RST_BYTE;
            next_state.rdata[FPS_STAT_BUSY] = state.phase != FPS_IDLE;
            next_state.rdata[FPS_STAT_REFUSED] = state.refused;
            next_state.rdata[FPS_STAT_DOWNLOAD] = state.download;
            next_state.rdata[FPS_STAT_SCHEME] = scheme_on;
         end
         default: next_state.rdata = FPS_RST_BYTE;
      endcase

      // register writes, ignored while an operation runs
      if (wr_en && state.phase == FPS_IDLE && !state.strap_pending)
      begin
         case (wr_addr)
            FPS_ADDR_ADDR_HIGH:
            begin
               next_state.addr_high = wr_data; // [RULE4]
            end
            FPS_ADDR_ADDR_LOW:
            begin
               next_state.addr_low = wr_data;
            end
            FPS_ADDR_DATA:
            begin
               next_state.data = wr_data;
            end
            FPS_ADDR_KEY:
            begin
               next_state.key = wr_data;
            end
            FPS_ADDR_PROT_B0:
            begin
               next_state.prot_b0 = wr_data;
            end
            FPS_ADDR_PROT_B1:
            begin
               next_state.prot_b1 = wr_data;
            end
            FPS_ADDR_PROT_READ:
            begin
               next_state.prot_read = wr_data;
            end
            FPS_ADDR_PROT_KEY:
            begin
               next_state.prot_key = wr_data;
            end
            FPS_ADDR_CMD:
            begin
               next_state.cmd = wr_data;
               next_state.key = FPS_RST_BYTE; // key is spent by any command
               if (key_ok && allowed) // [RULE19]
               begin
                  next_state.refused = 1'b0;
                  next_state.phase = FPS_RUN; // [RULE12] [RULE23]
                  next_state.cnt = op_cycles;
                  next_state.flash.go = 1'b1;
                  next_state.flash.cmd = wr_data;
                  next_state.flash.addr = {state.addr_high[5:0], state.addr_low};
                  next_state.flash.wdata = state.data;
                  // staged bytes in flash order; a set key stays as it is
                  next_state.flash.prot = {state.addr_high, state.addr_low,
                     state.prot_b1, state.prot_b0, state.prot_read,
                     (state.pkey == FPS_RST_PROT_BYTE) ? state.prot_key
                                                       : FPS_RST_PROT_BYTE}; // [RULE20]
               end
               else
               begin
                  next_state.refused = 1'b1;
               end
            end
            default:
            begin
               next_state.refused = state.refused;
            end
         endcase
      end

      // operation timing
      case (state.phase)
         FPS_IDLE:
         begin
         end
         FPS_RUN:
         begin
            if (state.cnt <= 23'h000001)
            begin
               next_state.phase = FPS_DONE;
            end
            else
            begin
               next_state.cnt = state.cnt - 23'h000001; // [RULE11]
            end
         end
         FPS_DONE:
         begin
            // read result lands as the stall drops
            if (state.flash.cmd == FPS_CMD_READ)
            begin
               next_state.data = i_flash_rdata;
            end
            next_state.phase = FPS_IDLE; // [RULE23]
         end
         default:
         begin
            next_state.phase = FPS_IDLE;
         end
      endcase

      // synchronous reset, synchroniser keeps shifting
      if (i_rst)
      begin
         next_state = '0;
         next_state.strap_sync = {state.strap_sync[1:0], i_download_enable_n};
         next_state.strap_pending = 1'b1;
         next_state.wp = FPS_RST_PROT_ALL[47:16]; // [RULE5]
         next_state.rp = FPS_RST_PROT_BYTE;
         next_state.pkey = FPS_RST_PROT_BYTE;
         next_state.prot_b0 = FPS_RST_PROT_BYTE;
         next_state.prot_b1 = FPS_RST_PROT_BYTE;
         next_state.prot_read = FPS_RST_PROT_BYTE;
         next_state.prot_key = FPS_RST_PROT_BYTE;
         next_state.phase = FPS_IDLE;
      end
   end

   // state register
   always_ff @(posedge i_clk_sys)
   begin
      state <= next_state;
   end

   // outputs straight from the state register
   assign o_flash = state.flash;
   assign o_sfr_rdata = state.rdata;
   assign o_working_register_zero = state.r0;
   assign o_download_mode = state.download;
   // phase bit 0 is set in run and done only, so busy is a plain flop bit
   assign o_core_stall = state.phase[0]; // [RULE12] [RULE23]
   assign o_irq_block = state.phase[0]; // [RULE13] [RULE23]
   assign o_op_refused = state.refused;

endmodule

/* testbench/fps_checker.sv */
`timescale 1ns/1ps
module fps_checker
   import fps_pkg::*;
#(
   parameter int P_CYC_ERASE_PAGE = FPS_CYC_ERASE_PAGE,
   parameter int P_CYC_ERASE_ALL = FPS_CYC_ERASE_ALL,
   parameter int P_CYC_ERASE_WRITE = FPS_CYC_ERASE_WRITE
)
(
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire fps_sfr_type i_sfr,
   input wire fps_emu_type i_emu,
   input wire fps_flash_type o_flash,
   input wire logic [7:0] o_working_register_zero,
   input wire logic o_download_mode,
   input wire logic o_core_stall,
   input wire logic o_irq_block,
   input wire logic o_op_refused
);
   int len;
   int since_rst;
   int exp_len;

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);

   // stall length and cycles since reset release
   always_ff @(posedge i_clk_sys)
   begin
      len <= (i_rst || !o_core_stall) ? 0 : len + 1;
      since_rst <= i_rst ? 0 : (since_rst < 15 ? since_rst + 1 : since_rst);
   end

   // expected run cycles of the standing command; busy lasts one cycle more
   always_comb
   begin
      case (o_flash.cmd)
         FPS_CMD_WRITE: exp_len = FPS_CYC_WRITE;
         FPS_CMD_ERASE_PAGE: exp_len = P_CYC_ERASE_PAGE;
         FPS_CMD_ERASE_ALL: exp_len = P_CYC_ERASE_ALL;
         FPS_CMD_ERASE_WRITE: exp_len = P_CYC_ERASE_WRITE;
         FPS_CMD_PROTECT: exp_len = FPS_PROT_BYTES * FPS_CYC_WRITE;
         default: exp_len = FPS_CYC_READ;
      endcase
   end

   AST_STALL_IRQ: assert property (o_core_stall == o_irq_block)
      else $error("irq block differs from stall");
   AST_GO_STALL: assert property (o_flash.go |-> o_core_stall ##1 o_core_stall)
      else $error("go without busy stall");
   AST_GO_IDLE: assert property (o_flash.go |-> !$past(o_core_stall))
      else $error("operation started while busy");
   AST_OP_LEN: assert property ($fell(o_core_stall) |-> len == exp_len + 1)
      else $error("operation length wrong");
   AST_CMD_ANSWER: assert property (i_sfr.wr && i_sfr.addr == FPS_ADDR_CMD && !o_core_stall
      && since_rst > 5 |=> o_flash.go || o_op_refused)
      else $error("command write got no answer");
   AST_NO_REFUSED_GO: assert property (o_flash.go |-> !o_op_refused)
      else $error("refused and started together");
   AST_EMU_LOAD: assert property (i_emu.valid && i_emu.code == FPS_EMU_LOAD && o_download_mode
      |=> o_working_register_zero == $past(i_emu.data))
      else $error("load did not reach working register");
   AST_EMU_IGNORED: assert property (i_emu.valid && !o_download_mode
      |=> $stable(o_working_register_zero))
      else $error("emulator command acted outside download");
   AST_DL_STEADY: assert property ($changed(o_download_mode) |-> since_rst < 8)
      else $error("download mode changed outside reset");
endmodule

bind fps_top fps_checker #(.P_CYC_ERASE_PAGE(P_CYC_ERASE_PAGE),
   .P_CYC_ERASE_ALL(P_CYC_ERASE_ALL), .P_CYC_ERASE_WRITE(P_CYC_ERASE_WRITE)) chk (
   .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_sfr(i_sfr), .i_emu(i_emu), .o_flash(o_flash),
   .o_working_register_zero(o_working_register_zero), .o_download_mode(o_download_mode),
   .o_core_stall(o_core_stall), .o_irq_block(o_irq_block), .o_op_refused(o_op_refused));

/* testbench/fps_flash_model.sv */
`timescale 1ns/1ps
module fps_flash_model
   import fps_pkg::*;
(
   input wire logic i_clk_sys,
   input wire fps_flash_type i_flash,
   output logic [7:0] o_rdata,
   output logic [47:0] o_nv_prot
);
   logic [7:0] mem [0:16383];

   // erased array, protection open
   initial
   begin
      foreach (mem[i]) mem[i] = 8'hff;
      o_nv_prot = FPS_RST_PROT_ALL;
      o_rdata = 8'h00;
   end

   // one request per go pulse; stale read data is not held
   always @(posedge i_clk_sys)
   begin
      if (i_flash.go)
      begin
         o_rdata <= ~o_rdata;
         case (i_flash.cmd)
            FPS_CMD_WRITE: mem[i_flash.addr] <= mem[i_flash.addr] & i_flash.wdata;
            FPS_CMD_READ, FPS_CMD_VERIFY: o_rdata <= mem[i_flash.addr];
            FPS_CMD_ERASE_PAGE, FPS_CMD_ERASE_WRITE:
            begin
               for (int i = 0; i < 512; i++) mem[{i_flash.addr[13:9], i[8:0]}] <= 8'hff;
               if (i_flash.cmd == FPS_CMD_ERASE_WRITE)
                  mem[i_flash.addr] <= i_flash.wdata;
            end
            FPS_CMD_ERASE_ALL:
            begin
               foreach (mem[i]) mem[i] <= 8'hff;
               o_nv_prot <= FPS_RST_PROT_ALL;
            end
            FPS_CMD_PROTECT: o_nv_prot <= o_nv_prot & i_flash.prot;
            default: ;
         endcase
      end
   end
endmodule

/* testbench/flash_protection_sequencer_tb.sv */
`timescale 1ns/1ps
module flash_protection_sequencer_tb;
   import fps_pkg::*;
   logic i_clk_sys = 1'b0;
   logic i_rst;
   logic dl_n;
   fps_sfr_type sfr = '0;
   fps_emu_type emu = '0;
   fps_flash_type flash;
   logic [47:0] nv;
   logic [7:0] frd, rdata, r0, base, v;
   logic dl, stall, irqb, refused;
   logic [8:0] exp_q[$];
   logic [8:0] e;
   int n_mismatch = 0;
   int samples_checked = 0;
   int issued = 0;
   int seen = 0;
   int done = 0;
   int cyc = 0;

   fps_top #(.P_CYC_ERASE_PAGE(20), .P_CYC_ERASE_ALL(40), .P_CYC_ERASE_WRITE(21)) uut (
      .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_download_enable_n(dl_n), .i_sfr(sfr),
      .i_emu(emu), .i_nv_prot(nv), .i_flash_rdata(frd), .o_flash(flash), .o_sfr_rdata(rdata),
      .o_working_register_zero(r0), .o_download_mode(dl), .o_core_stall(stall),
      .o_irq_block(irqb), .o_op_refused(refused));
   fps_flash_model fm (.i_clk_sys(i_clk_sys), .i_flash(flash), .o_rdata(frd), .o_nv_prot(nv));

   // clock, watchdog and answer tracking
   always #20 i_clk_sys = ~i_clk_sys;
   always @(posedge i_clk_sys)
   begin
      cyc <= cyc + 1;
      seen <= issued;
      if (cyc == 60000)
      begin
         n_mismatch++;
         stop_test();
      end
   end

   // compare the oldest expectation once its answer has settled
   always @(negedge i_clk_sys)
   begin
      if (seen != done)
      begin
         done++;
         e = exp_q.pop_front();
         samples_checked++;
         if ((e[8] ? r0 : rdata) !== e[7:0])
         begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", e[8] ? "r0" : "rdata", e[7:0],
               e[8] ? r0 : rdata);
         end
      end
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic tick();
      @(posedge i_clk_sys);
      #1;
   endtask

   task automatic idle();
      sfr.wr = 1'b0;
      emu.valid = 1'b0;
      tick();
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr = '{1'b1, a, d};
      tick();
   endtask

   // x[8] picks working register zero instead of read data
   task automatic rd(input logic [7:0] a, input logic [8:0] x);
      sfr = '{1'b0, a, 8'h00};
      exp_q.push_back(x);
      issued++;
      tick();
   endtask

   task automatic em(input logic [7:0] c, input logic [7:0] d);
      emu = '{1'b1, c, d};
      tick();
   endtask

   task automatic ew(input logic [7:0] a, input logic [7:0] d);
      em(FPS_EMU_LOAD, d);
      em(FPS_EMU_STORE, a);
   endtask

   task automatic wait_idle();
      for (int i = 0; i < 5000 && stall !== 1'b0; i++)
         tick();
      if (stall !== 1'b0)
      begin
         n_mismatch++;
         $display("BAD stall expected 0 seen %b", stall);
      end
   endtask

   task automatic op(input logic [7:0] c, input logic [15:0] a, input logic ok, input logic k);
      wr(FPS_ADDR_ADDR_HIGH, a[15:8]);
      wr(FPS_ADDR_ADDR_LOW, a[7:0]);
      if (k)
         wr(FPS_ADDR_KEY, FPS_ACCESS_KEY);
      wr(FPS_ADDR_CMD, c);
      idle();
      rd(FPS_ADDR_STATUS, {1'b0, base | (ok ? 8'h01 : 8'h02)});
      idle();
      wait_idle();
   endtask

   task automatic rst(input logic pin, input int n, input logic [7:0] b);
      dl_n = pin;
      i_rst = 1'b1;
      repeat (n) tick();
      i_rst = 1'b0;
      base = b;
      repeat (4) tick();
   endtask

   // main sequence
   initial
   begin
      v = $urandom(99819);
      rst(1'b1, 12, 8'h00);
      rd(FPS_ADDR_STATUS, 9'h000);
      rd(8'h80, 9'h000);
      em(FPS_EMU_LOAD, 8'h5a);
      idle();
      rd(8'h80, 9'h100);
      op(FPS_CMD_WRITE, 16'h0123, 1'b0, 1'b0);
      op(FPS_CMD_ERASE_PAGE, 16'h0123, 1'b1, 1'b1);
      op(FPS_CMD_READ, 16'h0123, 1'b1, 1'b1);
      rd(FPS_ADDR_DATA, 9'h0ff);
      v = $urandom & 8'h7f;
      wr(FPS_ADDR_DATA, v);
      op(FPS_CMD_ERASE_WRITE, 16'h0123, 1'b1, 1'b1);
      wr(FPS_ADDR_DATA, 8'h80);
      op(FPS_CMD_READ, 16'h0123, 1'b1, 1'b1);
      rd(FPS_ADDR_DATA, {1'b0, v});
      op(FPS_CMD_VERIFY, 16'h0123, 1'b1, 1'b1);
      $display("test 1 done");
      wr(FPS_ADDR_PROT_B1, 8'hff);
      wr(FPS_ADDR_PROT_B0, 8'hff);
      wr(FPS_ADDR_PROT_READ, 8'h7f);
      wr(FPS_ADDR_PROT_KEY, 8'ha3);
      op(FPS_CMD_PROTECT, 16'h7fff, 1'b1, 1'b1);
      op(FPS_CMD_WRITE, 16'h3e00, 1'b1, 1'b1);
      $display("test 2 done");
      rst(1'b1, 3, 8'h08);
      rd(FPS_ADDR_STATUS, 9'h008);
      op(FPS_CMD_WRITE, 16'h3e00, 1'b0, 1'b1);
      op(FPS_CMD_WRITE, 16'h0000, 1'b1, 1'b1);
      op(FPS_CMD_READ, 16'h3e00, 1'b1, 1'b1);
      op(FPS_CMD_PROTECT, 16'h7fff, 1'b0, 1'b1);
      $display("test 3 done");
      rst(1'b0, 3, 8'h0c);
      rd(FPS_ADDR_STATUS, 9'h00c);
      op(FPS_CMD_READ, 16'h3e00, 1'b0, 1'b1);
      op(FPS_CMD_READ, 16'h3600, 1'b1, 1'b1);
      op(FPS_CMD_ERASE_PAGE, 16'h3e00, 1'b0, 1'b1);
      op(FPS_CMD_PROTECT, 16'h7fff, 1'b0, 1'b1);
      v = $urandom;
      ew(FPS_ADDR_ADDR_LOW, v);
      idle();
      rd(FPS_ADDR_ADDR_LOW, {1'b0, v});
      rd(8'h80, {1'b1, v});
      ew(FPS_ADDR_ADDR_HIGH, 8'hff);
      ew(FPS_ADDR_ADDR_LOW, 8'hff);
      ew(FPS_ADDR_PROT_B1, 8'hff);
      ew(FPS_ADDR_PROT_B0, 8'hfe);
      ew(FPS_ADDR_PROT_READ, 8'hff);
      ew(FPS_ADDR_PROT_KEY, 8'ha3);
      ew(FPS_ADDR_KEY, FPS_ACCESS_KEY);
      ew(FPS_ADDR_CMD, FPS_CMD_PROTECT);
      idle();
      rd(FPS_ADDR_STATUS, 9'h00d);
      idle();
      wait_idle();
      $display("test 4 done");
      rst(1'b1, 3, 8'h08);
      op(FPS_CMD_WRITE, 16'h0000, 1'b0, 1'b1);
      op(FPS_CMD_ERASE_ALL, 16'h0000, 1'b1, 1'b1);
      rst(1'b1, 3, 8'h00);
      op(FPS_CMD_WRITE, 16'h3e00, 1'b1, 1'b1);
      $display("test 5 done");
      stop_test();
   end
endmodule
